// ==== dv/mtps_stack_model.sv ====
`timescale 1ns/1ps
module mtps_stack_model
  import mtps_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // Cycle request
  input  wire logic              mem_start,
  input  wire logic              mem_write,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [WORD_W-1:0] mem_wdata,
  // Answer
  output logic      [WORD_W-1:0] mem_rdata,
  output logic                   mem_done,
  // Test knobs
  input  wire logic              slow,
  input  wire logic              corrupt
);
  logic [WORD_W-1:0] store [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] addr_r;
  logic [WORD_W-1:0] data_r;
  logic              write_r;
  int                cnt_r;

  // Erased stack reads all ones
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      store[i] = '1;
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 0;
      mem_done <= 1'b0;
      mem_rdata <= '0;
    end else if (mem_start) begin
      // Released sense lines show junk, never the last word
      mem_done <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt_r <= slow ? 20 : 3;
      addr_r <= mem_addr;
      data_r <= mem_wdata;
      write_r <= mem_write;
    end else if (cnt_r > 1) begin
      cnt_r <= cnt_r - 1;
      // Word settles one cycle before done; a fault flips parity
      if (cnt_r == 2) begin
        mem_rdata <= write_r ? ~mem_rdata : store[addr_r] ^ {corrupt, 48'h0000_0000_0000};
      end
    end else if (cnt_r == 1) begin
      cnt_r <= 0;
      mem_done <= 1'b1;
      if (write_r) begin
        store[addr_r] <= data_r;
      end
    end
  end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import mtps_pkg::*;
  logic              clk_sys, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              mem_start, mem_write, mem_done, mem_unavailable;
  logic [ADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_wdata, mem_rdata;
  logic              p100, sfail, lk_o, lk_oe_n, lk_line, slow, corrupt;
  logic [3:0]        relay_en;
  logic              l_mode, l_lpwr, l_spwr, l_err, l_busy;
  logic [61:0]       q[$];
  int                error_cnt = 0;
  int                checked = 0;
  int                cyc = 0;
  localparam logic [31:0] BASE = 32'((1 << CB_LOCAL) | (1 << CB_PWRON));

  // Open-drain lockout line with pull-up
  assign lk_line = lk_oe_n ? 1'b1 : lk_o;

  mtps_top i_mtps_top (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_start(mem_start), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_done(mem_done),
    .mem_unavailable(mem_unavailable), .supply_p100_ok(p100), .special_supply_fail(sfail),
    .relay_en(relay_en), .supply_lockout_line_i(lk_line), .supply_lockout_line_o(lk_o),
    .supply_lockout_line_oe_n(lk_oe_n), .lamp_local_mode(l_mode), .lamp_local_power(l_lpwr),
    .lamp_system_power(l_spwr), .lamp_error(l_err), .lamp_busy(l_busy));

  mtps_stack_model i_mtps_stack_model (.clk_sys(clk_sys), .resetn(resetn),
    .mem_start(mem_start), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_done(mem_done),
    .slow(slow), .corrupt(corrupt));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (resetn && mem_start === 1'b1) begin
      q.push_back({mem_write, mem_addr, mem_wdata});
    end
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_relays(input logic [3:0] v);
    for (int i = 0; i < 1200 && relay_en !== v; i++) @(posedge clk_sys);
  endtask

  function automatic logic [WORD_W-1:0] pat(input logic w, input logic [NGRP-1:0] g);
    logic [WORD_W-1:0] p;
    for (int i = 0; i < WORD_W; i++) p[i] = ~(w ^ g[(i == WORD_W-1) ? NGRP-1 : i % NGRP]);
    return p;
  endfunction

  // Stop-at-final ends each run on an operation boundary at the top address, unless stop-on-error ends it sooner after a mismatching read
  task automatic run_ops(input logic [31:0] ctrl, input int ops, input int n);
    apb(OFF_ADDR, 1'b1, 32'((1 << ADDR_W) - ops));
    apb(OFF_CTRL, 1'b1, ctrl | (1 << CB_CONT) | (1 << CB_STOPFIN));
    q.delete();
    apb(OFF_CMD, 1'b1, 32'h0000_0001);
    @(posedge clk_sys);
    chk("busy lamp", 1, l_busy);
    for (int i = 0; i < 400; i++) begin
      apb(OFF_STATUS, 1'b0, 32'h0000_0000);
      if (rd[ST_BUSY] === 1'b0 && rd[ST_RUN] === 1'b0 && q.size() >= n) break;
    end
    chk("cycle count", n, q.size());
    chk("busy lamp off", 0, l_busy);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    apb(8'h18, 1'b0, 32'h0000_0000);
    chk("unmapped error", 1, err);
    repeat (300) @(posedge clk_sys);
    chk("relays before +100", 0, relay_en);
    p100 <= 1'b1;
    wait_relays(4'h1);
    chk("first relay", 4'h1, relay_en);
    wait_relays(4'hF);
    chk("system lamp", 1, l_spwr);
    apb(OFF_CTRL, 1'b1, BASE);
    p100 <= 1'b0;
    apb(OFF_CTRL, 1'b1, 32'h0000_0001);
    repeat (5) @(posedge clk_sys);
    chk("relays off", 0, relay_en);
    chk("unavailable", 1, mem_unavailable);
    chk("local lamp", 1, l_mode);
    apb(OFF_CTRL, 1'b1, BASE);
    wait_relays(4'h1);
    chk("local first relay", 4'h1, relay_en);
    wait_relays(4'hF);
    chk("local power lamp", 1, l_lpwr);
    $display("test power done");
  endtask

  task automatic t_patterns();
    logic [NGRP-1:0] g;
    for (int w = 0; w < 2; w++) begin
      for (int k = 0; k <= NGRP; k++) begin
        g = (k < NGRP) ? NGRP'(1 << k) : '0;
        run_ops(BASE | (w << CB_WORD) | (g << CB_GRP), 1, 2);
        chk("read word", pat(w[0], g), q[0][WORD_W-1:0]);
        chk("write word", pat(w[0], g), q[1][WORD_W-1:0]);
      end
    end
    $display("test patterns done");
  endtask

  task automatic t_modes();
    logic [31:0] mb [5] = '{1 << CB_PCCL, (1 << CB_AUTO) | (1 << CB_PCCL), 1 << CB_AUTO,
                           (1 << CB_CHECK) | (1 << CB_PCCL), (1 << CB_CHECK) | (1 << CB_AUTO)};
    logic [4:0] cb = 5'b11000;
    logic [4:0] four = 5'b01010;
    logic [WORD_W-1:0] p;
    logic [ADDR_W-1:0] a;
    logic inv;
    int ph;
    p = pat(1'b0, 6'h04);
    for (int r = 0; r < 5; r++) begin
      slow <= (r == 3);
      run_ops(BASE | mb[r] | (32'h0000_0004 << CB_GRP), 2, four[r] ? 8 : 4);
      for (int k = 0; k < (four[r] ? 8 : 4); k++) begin
        ph = four[r] ? k % 4 : k % 2;
        a = ADDR_W'((1 << ADDR_W) - 2 + (four[r] ? k / 4 : k / 2));
        inv = (four[r] && ph inside {1, 2}) ^ (cb[r] && (a[0] ^ a[6]));
        chk("cycle dir", ph[0], q[k][WORD_W+ADDR_W]);
        chk("cycle addr", a, q[k][WORD_W +: ADDR_W]);
        chk("cycle word", p ^ {WORD_W{inv}}, q[k][WORD_W-1:0]);
      end
    end
    slow <= 1'b0;
    $display("test modes done");
  endtask

  task automatic t_error();
    run_ops(BASE, 1, 2);
    apb(OFF_CMD, 1'b1, 32'h0000_0004);
    run_ops(BASE, 1, 2);
    chk("clean read", 0, l_err);
    corrupt <= 1'b1;
    run_ops(BASE, 1, 2);
    apb(OFF_STATUS, 1'b0, 32'h0000_0000);
    chk("parity fault", 1, rd[ST_ERR]);
    chk("error lamp", 1, l_err);
    corrupt <= 1'b0;
    apb(OFF_CMD, 1'b1, 32'h0000_0004);
    @(posedge clk_sys);
    chk("error cleared", 0, l_err);
    apb(OFF_ADDR, 1'b1, 32'h0000_0010);
    apb(OFF_CMD, 1'b1, 32'h0000_0002);
    apb(OFF_ADDR, 1'b0, 32'h0000_0000);
    chk("step address", 32'h0000_0011, rd);
    corrupt <= 1'b1;
    run_ops(BASE | (1 << CB_STOPERR), 2, 1);
    corrupt <= 1'b0;
    $display("test error done");
  endtask

  task automatic t_stop_fault();
    apb(OFF_CTRL, 1'b1, BASE | (1 << CB_CLKSTOP));
    q.delete();
    apb(OFF_CMD, 1'b1, 32'h0000_0001);
    repeat (40) @(posedge clk_sys);
    chk("stopped cycles", 0, q.size());
    apb(OFF_CTRL, 1'b1, BASE | (1 << CB_PWRRST));
    sfail <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk("sensing held", 1, lk_oe_n);
    apb(OFF_CTRL, 1'b1, BASE);
    repeat (20) @(posedge clk_sys);
    chk("lockout grounded", 0, lk_line);
    chk("relays dropped", 0, relay_en);
    sfail <= 1'b0;
    $display("test stop and fault done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    p100 = 1'b0;
    sfail = 1'b0;
    slow = 1'b0;
    corrupt = 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    chk("lockout idle", 1, lk_oe_n);
    t_power();
    t_patterns();
    t_modes();
    t_error();
    t_stop_fault();
    report_and_stop();
  end
endmodule

// ==== rtl/mtps_pattern.sv ====
`timescale 1ns/1ps
module mtps_pattern
  import mtps_pkg::*;
(
  // Switch settings and checkerboard invert
  input  wire logic                word_up,
  input  wire logic [NGRP-1:0]     grp_up,
  input  wire logic                invert,
  // Test word
  output logic      [WORD_W-1:0]   pattern
);
  import mtps_pkg::*;

  // Bit i+1 of the word belongs to group i mod 6; the parity bit joins the last group
  for (genvar i = 0; i < WORD_W; i++) begin : g_bit
    localparam int unsigned GRP = (i == WORD_W - 1) ? NGRP - 1 : i % NGRP;
    assign pattern[i] = ~(word_up ^ grp_up[GRP] ^ invert); // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8]
  end

endmodule

// ==== rtl/mtps_pkg.sv ====
package mtps_pkg;

  // Word and address geometry
  localparam int unsigned WORD_W = 49;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NGRP   = 6;

  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_ADDR   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_RDLO   = 8'h10;
  localparam logic [7:0] OFF_RDHI   = 8'h14;

  // Control register: one bit per maintenance panel switch
  localparam int unsigned CB_LOCAL   = 0;
  localparam int unsigned CB_CHECK   = 1;
  localparam int unsigned CB_AUTO    = 2;
  localparam int unsigned CB_PCCL    = 3;
  localparam int unsigned CB_WORD    = 4;
  localparam int unsigned CB_GRP     = 5;
  localparam int unsigned CB_CLKSTOP = 11;
  localparam int unsigned CB_PWRON   = 12;
  localparam int unsigned CB_PWRRST  = 13;
  localparam int unsigned CB_CONT    = 14;
  localparam int unsigned CB_STOPERR = 15;
  localparam int unsigned CB_STOPFIN = 16;
  localparam int unsigned CB_INHCNT  = 17;
  localparam int unsigned CTRL_W     = 18;
  localparam logic [CTRL_W-1:0] CTRL_RST = 18'h0_0000;

  // Command register: write-one pulses
  localparam int unsigned CMD_START  = 0;
  localparam int unsigned CMD_STEP   = 1;
  localparam int unsigned CMD_CLRERR = 2;

  // Status register fields
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_RUN     = 1;
  localparam int unsigned ST_ERR     = 2;
  localparam int unsigned ST_FAULT   = 3;
  localparam int unsigned ST_P100    = 4;
  localparam int unsigned ST_POWERED = 5;
  localparam int unsigned ST_PHASE   = 6;
  localparam int unsigned ST_RELAY   = 8;
  localparam int unsigned ST_LOCKOUT = 12;

  // Timing
  localparam int unsigned CLK_NS         = 4;
  localparam int unsigned RELAY_STEP_NS  = 1000;
  localparam int unsigned RELAY_STEP_CYC = (RELAY_STEP_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic {MTPS_IDLE, MTPS_WAIT} mtps_state_e;

endpackage

// ==== rtl/mtps_top.sv ====
// Notes on behaviour
// RULE1 - 2s group bits set when normal
// RULE2 - 4s group bits set when normal
// RULE3 - 8s group bits set when normal
// RULE4 - As group bits set when normal
// RULE5 - Bs group plus parity set
// RULE6 - Group switch up inverts that group
// RULE7 - 1s group bits set when normal
// RULE8 - All normal gives all ones; word inverts
// RULE9 - Checkerboard selector overrides automatic/manual
// RULE10 - Manual down, automatic up under uniform
// RULE11 - Cycle selector ignored in manual mode
// RULE12 - Normal: read then write, normal pattern
// RULE13 - Up: read, write cmp, read cmp, write
// RULE14 - Address increments after each operation
// RULE15 - Local clock stop freezes all cycling
// RULE16 - Power reset inhibits failure sensing
// RULE17 - Online: wait for +100 before sequencing
// RULE18 - Lockout grounded only on own failure
// RULE19 - Local: four relays under power switch
// RULE20 - Lamps follow their flip-flop or state
// RULE21 - Checkerboard alternates pattern between neighbours
// RULE22 - Reads compared, mismatch sets error flag
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module mtps_top
  import mtps_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Core memory stack
  output logic                     mem_start,
  output logic                     mem_write,
  output logic      [ADDR_W-1:0]   mem_addr,
  output logic      [WORD_W-1:0]   mem_wdata,
  input  wire logic [WORD_W-1:0]   mem_rdata,
  input  wire logic                mem_done,
  output logic                     mem_unavailable,
  // Power sequencing
  input  wire logic                supply_p100_ok,
  input  wire logic                special_supply_fail,
  output logic      [3:0]          relay_en,
  input  wire logic                supply_lockout_line_i,
  output logic                     supply_lockout_line_o,
  output logic                     supply_lockout_line_oe_n,
  // Panel lamps
  output logic                     lamp_local_mode,
  output logic                     lamp_local_power,
  output logic                     lamp_system_power,
  output logic                     lamp_error,
  output logic                     lamp_busy
);
  import mtps_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0]  ctrl;
    logic [ADDR_W-1:0]  addr;
    mtps_state_e        st;
    logic [1:0]         phase;
    logic               run;
    logic               err;
    logic               fault;
    logic [3:0]         relays;
    logic [7:0]         rcnt;
    logic               done_s1;
    logic               done_s2;
    logic               done_s3;
    logic               p100_s1;
    logic               p100_s2;
    logic               fail_s1;
    logic               fail_s2;
    logic               lk_s1;
    logic               lk_s2;
    logic [WORD_W-1:0]  rd_s1;
    logic [WORD_W-1:0]  rd_s2;
    logic [WORD_W-1:0]  rd_last;
    logic [WORD_W-1:0]  wdata;
    logic               start;
    logic               wr;
    logic [31:0]        prdata;
  } mtps_regs_s;

  mtps_regs_s         s_r;
  mtps_regs_s         s_nxt;

  logic               apb_wr;
  logic               apb_setup;
  logic               addr_hit;
  logic               start_cmd;
  logic               step_cmd;
  logic               clrerr_cmd;
  logic               is_local;
  logic               chkb_mode;
  logic               pccl_eff;
  logic [1:0]         last_phase;
  logic               powered;
  logic               tick;
  logic               done_ev;
  logic               issue;
  logic               op_done;
  logic               mismatch;
  logic               err_set;
  logic               power_target;
  logic               fault_set;
  logic               chk_odd;
  logic [WORD_W-1:0]  pat_norm;
  logic [WORD_W-1:0]  pat_cmp;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and mode selection

  assign apb_setup  = psel & ~penable;
  assign apb_wr     = psel & penable & pwrite;
  assign addr_hit   = (paddr == OFF_CTRL) | (paddr == OFF_CMD) | (paddr == OFF_ADDR) |
                      (paddr == OFF_STATUS) | (paddr == OFF_RDLO) | (paddr == OFF_RDHI);
  assign start_cmd  = apb_wr & (paddr == OFF_CMD) & pwdata[CMD_START];
  assign step_cmd   = apb_wr & (paddr == OFF_CMD) & pwdata[CMD_STEP];
  assign clrerr_cmd = apb_wr & (paddr == OFF_CMD) & pwdata[CMD_CLRERR];

  assign is_local   = s_r.ctrl[CB_LOCAL];
  assign chkb_mode  = s_r.ctrl[CB_CHECK];                             // [RULE9]
  // Manual mode is uniform with automatic down; it never sees the cycle selector
  assign pccl_eff   = s_r.ctrl[CB_PCCL] & (chkb_mode | s_r.ctrl[CB_AUTO]); // [RULE10] [RULE11]
  assign last_phase = pccl_eff ? 2'd3 : 2'd1;                         // [RULE12] [RULE13]
  assign powered    = &s_r.relays;
  // A stopped clock freezes the sequencer; a cycle whose done edge comes while stopped stays in wait after restart
  assign tick       = is_local & ~s_r.ctrl[CB_CLKSTOP] & powered;     // [RULE15]
  assign done_ev    = s_r.done_s2 & ~s_r.done_s3;
  assign issue      = tick & (s_r.st == MTPS_IDLE) & (start_cmd | s_r.run);
  assign op_done    = tick & (s_r.st == MTPS_WAIT) & done_ev & (s_r.phase == last_phase);
  assign mismatch   = ~s_r.wr & (s_r.rd_s2 != s_r.wdata);             // [RULE22]
  assign err_set    = tick & (s_r.st == MTPS_WAIT) & done_ev & mismatch;

  // Neighbouring X and Y lines take opposite patterns in checkerboard mode
  assign chk_odd    = chkb_mode & (s_r.addr[0] ^ s_r.addr[ADDR_W/2]); // [RULE21]

  mtps_pattern u_pat_norm (
    .word_up (s_r.ctrl[CB_WORD]),
    .grp_up  (s_r.ctrl[CB_GRP +: NGRP]),
    .invert  (chk_odd),
    .pattern (pat_norm)
  );

  mtps_pattern u_pat_cmp (
    .word_up (s_r.ctrl[CB_WORD]),
    .grp_up  (s_r.ctrl[CB_GRP +: NGRP]),
    .invert  (~chk_odd),
    .pattern (pat_cmp)
  );

  // Online the stack waits for the last system supply; locally the panel switch rules
  assign power_target = (is_local ? s_r.ctrl[CB_PWRON] : s_r.p100_s2) & ~s_r.fault; // [RULE17] [RULE19]
  assign fault_set    = s_r.fail_s2 & ~s_r.ctrl[CB_PWRRST] & (s_r.relays != 4'h0); // [RULE16]

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt         = s_r;
    s_nxt.done_s1 = mem_done;
    s_nxt.done_s2 = s_r.done_s1;
    s_nxt.done_s3 = s_r.done_s2;
    s_nxt.p100_s1 = supply_p100_ok;
    s_nxt.p100_s2 = s_r.p100_s1;
    s_nxt.fail_s1 = special_supply_fail;
    s_nxt.fail_s2 = s_r.fail_s1;
    s_nxt.lk_s1   = supply_lockout_line_i;
    s_nxt.lk_s2   = s_r.lk_s1;
    s_nxt.rd_s1   = mem_rdata;
    s_nxt.rd_s2   = s_r.rd_s1;
    s_nxt.start   = 1'b0;

    if (apb_wr && paddr == OFF_CTRL) begin
      s_nxt.ctrl = pwdata[CTRL_W-1:0];
    end

    // Error flag: a mismatch in the clearing cycle still sets it
    s_nxt.err = err_set | (s_r.err & ~clrerr_cmd);                    // [RULE22]

    if (!s_r.ctrl[CB_CONT]) begin
      s_nxt.run = 1'b0;
    end

    if (tick) begin
      unique case (s_r.st)
        MTPS_IDLE: begin
          if (start_cmd || s_r.run) begin
            if (start_cmd && s_r.ctrl[CB_CONT]) begin
              s_nxt.run = 1'b1;
            end
            // Even phases read, odd phases write; middle two use the complement
            s_nxt.st    = MTPS_WAIT;
            s_nxt.start = 1'b1;
            s_nxt.wr    = s_r.phase[0];                               // [RULE12]
            s_nxt.wdata = (pccl_eff && (s_r.phase == 2'd1 || s_r.phase == 2'd2)) ?
                          pat_cmp : pat_norm;                         // [RULE13]
          end else if (step_cmd) begin
            s_nxt.addr = s_r.addr + 1'b1;
          end
        end
        MTPS_WAIT: begin
          if (done_ev) begin
            s_nxt.st = MTPS_IDLE;
            if (!s_r.wr) begin
              s_nxt.rd_last = s_r.rd_s2;
            end
            if (err_set && s_r.ctrl[CB_STOPERR]) begin
              s_nxt.run = 1'b0;
            end
            if (s_r.phase == last_phase) begin
              s_nxt.phase = 2'd0;
              if (s_r.ctrl[CB_STOPFIN] && (&s_r.addr)) begin
                s_nxt.run = 1'b0;
              end else if (!s_r.ctrl[CB_INHCNT]) begin
                s_nxt.addr = s_r.addr + 1'b1;                         // [RULE14]
              end
            end else begin
              s_nxt.phase = s_r.phase + 2'd1;
            end
          end
        end
      endcase
    end

    // Leaving local mode abandons the test run
    if (!is_local) begin
      s_nxt.st    = MTPS_IDLE;
      s_nxt.run   = 1'b0;
      s_nxt.phase = 2'd0;
    end

    if (apb_wr && paddr == OFF_ADDR && s_r.st == MTPS_IDLE) begin
      s_nxt.addr = pwdata[ADDR_W-1:0];
    end

    // Relay chain closes one relay per step and drops all at once
    if (!power_target) begin
      s_nxt.relays = 4'h0;                                            // [RULE19]
      s_nxt.rcnt   = 8'h00;
    end else if (!powered) begin
      if (s_r.rcnt == 8'(RELAY_STEP_CYC - 1)) begin
        s_nxt.rcnt   = 8'h00;
        s_nxt.relays = {s_r.relays[2:0], 1'b1};                       // [RULE19]
      end else begin
        s_nxt.rcnt = s_r.rcnt + 8'h01;
      end
    end

    // Failure latches until power reset; the release also blocks detection
    s_nxt.fault = fault_set | (s_r.fault & ~s_r.ctrl[CB_PWRRST]);     // [RULE16] [RULE18]

    s_nxt.prdata = 32'h0000_0000;
    if (apb_setup && !pwrite) begin
      unique case (paddr)
        OFF_CTRL:   s_nxt.prdata = 32'(s_r.ctrl);
        OFF_ADDR:   s_nxt.prdata = 32'(s_r.addr);
        OFF_STATUS: begin
          s_nxt.prdata[ST_BUSY]          = (s_r.st != MTPS_IDLE);
          s_nxt.prdata[ST_RUN]           = s_r.run;
          s_nxt.prdata[ST_ERR]           = s_r.err;
          s_nxt.prdata[ST_FAULT]         = s_r.fault;
          s_nxt.prdata[ST_P100]          = s_r.p100_s2;
          s_nxt.prdata[ST_POWERED]       = powered;
          s_nxt.prdata[ST_PHASE +: 2]    = s_r.phase;
          s_nxt.prdata[ST_RELAY +: 4]    = s_r.relays;
          s_nxt.prdata[ST_LOCKOUT]       = s_r.lk_s2;
        end
        OFF_RDLO:   s_nxt.prdata = s_r.rd_last[31:0];
        OFF_RDHI:   s_nxt.prdata = 32'(s_r.rd_last[WORD_W-1:32]);
        default:    s_nxt.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata                   = s_r.prdata;
  assign pready                   = 1'b1;
  assign pslverr                  = psel & penable & ~addr_hit;
  assign mem_start                = s_r.start;
  assign mem_write                = s_r.wr;
  assign mem_addr                 = s_r.addr;
  assign mem_wdata                = s_r.wdata;
  assign mem_unavailable          = is_local;
  assign relay_en                 = s_r.relays;
  // Open-drain lockout: pulled to ground only by our own failure latch
  assign supply_lockout_line_o    = 1'b0;
  assign supply_lockout_line_oe_n = ~s_r.fault;                       // [RULE18]
  assign lamp_local_mode          = is_local;                         // [RULE20]
  assign lamp_local_power         = s_r.relays[3];                    // [RULE20]
  assign lamp_system_power        = s_r.p100_s2;                      // [RULE20]
  assign lamp_error               = s_r.err;                          // [RULE20]
  assign lamp_busy                = (s_r.st != MTPS_IDLE);            // [RULE20]

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence seq_issue_phase1;
    issue && pccl_eff && s_r.phase == 2'd1;
  endsequence

  sequence seq_write_cmp;
    mem_start && mem_write && mem_wdata == $past(pat_cmp);
  endsequence

  chk_all_ones_word: assert property ( // [RULE8]
    (s_r.ctrl[CB_WORD +: 1 + NGRP] == 7'h00 && !chkb_mode) |-> &pat_norm)
    else $error("normal switches did not give an all-ones word");

  chk_group_twos: assert property ( // [RULE1]
    !chk_odd |-> pat_norm[13] == ~(s_r.ctrl[CB_WORD] ^ s_r.ctrl[CB_GRP + 1]))
    else $error("2s group bit 14 wrong");

  chk_manual_two: assert property ( // [RULE11]
    (!chkb_mode && !s_r.ctrl[CB_AUTO]) |-> last_phase == 2'd1)
    else $error("manual mode used four-cycle operation");

  chk_four_cycle: assert property ( // [RULE13]
    seq_issue_phase1 |=> seq_write_cmp)
    else $error("second cycle was not a complement write");

  chk_clock_stop: assert property ( // [RULE15]
    (is_local && s_r.ctrl[CB_CLKSTOP]) |=> !mem_start)
    else $error("memory cycle started with clock stopped");

  chk_reset_inhibit: assert property ( // [RULE16]
    (s_r.ctrl[CB_PWRRST] && !s_r.fault) |=> !s_r.fault)
    else $error("failure sensed during power reset");

  chk_lockout_fault: assert property ( // [RULE18]
    !supply_lockout_line_oe_n |-> s_r.fault)
    else $error("lockout driven without failure");

  chk_relay_chain: assert property ( // [RULE19]
    (s_r.relays != 4'h0 && $changed(s_r.relays)) |->
      s_r.relays == (($past(s_r.relays) << 1) | 4'h1))
    else $error("relay chain skipped a step");

  chk_online_wait: assert property ( // [RULE17]
    (!is_local && !s_r.p100_s2) |=> s_r.relays == 4'h0)
    else $error("online relays closed without +100");

  chk_addr_step: assert property ( // [RULE14]
    (op_done && !s_r.ctrl[CB_INHCNT] && !(s_r.ctrl[CB_STOPFIN] && (&mem_addr))) |=>
      mem_addr == $past(mem_addr) + 12'h001)
    else $error("address did not advance after operation");

  chk_error_flag: assert property ( // [RULE22]
    err_set |=> lamp_error)
    else $error("read mismatch did not raise error");

endmodule
